// *** e1_fas_checker_assertions.sv ***
// Port-level checks of alignment loss and data link selection
`timescale 1ns/1ns
`include "e1_fas_map.vh"
module e1_fas_checker (
    input wire       clk_i,
    input wire       rst_i,
    input wire       rd_i,
    input wire [7:0] rdata_o,
    input wire       ts0_valid_i,
    input wire [7:0] ts0_byte_i,
    input wire       fas_frame_i,
    input wire       fas_loss_o,
    input wire       cas_mf_loss_o,
    input wire       crc_mf_loss_o,
    input wire [4:0] dl_bits_o,
    input wire [4:0] dl_mask_o,
    input wire       dl_valid_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_rise; !fas_loss_o ##1 fas_loss_o; endsequence
    sequence s_fall; fas_loss_o ##1 !fas_loss_o; endsequence
    property p_rise;
        s_rise |-> $past(ts0_valid_i, 2) && $past(fas_frame_i, 2)
            && $past(ts0_byte_i[6:0], 2) != `FAS_WORD;
    endproperty
    property p_fall;
        s_fall |-> $past(ts0_valid_i, 2) && $past(fas_frame_i, 2)
            && $past(ts0_byte_i[6:0], 2) == `FAS_WORD;
    endproperty
    property p_cas; cas_mf_loss_o == fas_loss_o; endproperty
    property p_crc; crc_mf_loss_o == fas_loss_o; endproperty
    property p_dl_bits;
        dl_valid_o |-> dl_bits_o == ($past(ts0_byte_i[7:3], 2) & dl_mask_o);
    endproperty
    property p_dl_nf;
        dl_valid_o |-> $past(ts0_valid_i, 2) && !$past(fas_frame_i, 2);
    endproperty
    property p_dl_en; dl_valid_o |-> dl_mask_o != 5'h00; endproperty
    property p_rd_idle; !$past(rd_i) |-> rdata_o == 8'h00; endproperty
    a_rise: assert property (p_rise) else $error("loss rose without bad word");
    a_fall: assert property (p_fall) else $error("loss fell without good word");
    a_cas: assert property (p_cas) else $error("cas loss differs");
    a_crc: assert property (p_crc) else $error("crc loss differs");
    a_dl_bits: assert property (p_dl_bits) else $error("dl bits wrong");
    a_dl_nf: assert property (p_dl_nf) else $error("dl from fas frame");
    a_dl_en: assert property (p_dl_en) else $error("dl with no enable");
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
endmodule

// *** e1_fas_loss_and_sa_datalink_select.v ***
// Top: registers, interrupt and glue for E1 FAS loss and Sa data link select
`timescale 1ns/1ns
`include "e1_fas_map.vh"
module e1_fas_loss_and_sa_datalink_select (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire [11:0] addr_i,
    input  wire [7:0]  wdata_i,
    input  wire        wr_i,
    input  wire        rd_i,
    output reg  [7:0]  rdata_o,
    input  wire        ts0_valid_i,
    input  wire [7:0]  ts0_byte_i,
    input  wire        fas_frame_i,
    output reg         fas_loss_o,
    output reg         cas_mf_loss_o,
    output reg         crc_mf_loss_o,
    output reg  [4:0]  dl_bits_o,
    output reg  [4:0]  dl_mask_o,
    output reg         dl_valid_o,
    output reg         irq_o
);
    reg  [7:0] framing_control_q;
    reg  [7:0] rx_sig_dl_select_q;
    reg  [2:0] irq_stat_q;
    reg  [2:0] irq_mask_q;
    wire       loss_lvl;
    wire       loss_pls;
    wire       regain_pls;
    wire [4:0] dl_bits;
    wire [4:0] dl_mask;
    wire       dl_valid;
    wire       wr_stat = wr_i && (addr_i == `ADDR_IRQ_STATUS);

    fas_loss_detect u_detect (
        .clk_i          (clk_i),
        .rst_i          (rst_i),
        .criteria_i     (framing_control_q[`CRIT_MSB:`CRIT_LSB]),
        .ts0_valid_i    (ts0_valid_i),
        .ts0_byte_i     (ts0_byte_i),
        .fas_frame_i    (fas_frame_i),
        .fas_loss_q     (loss_lvl),
        .loss_pulse_q   (loss_pls),
        .regain_pulse_q (regain_pls)
    );

    sa_datalink_extract u_extract (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .sa_en_i     (rx_sig_dl_select_q[`SA_EN_MSB:`SA_EN_LSB]),
        .route_i     (rx_sig_dl_select_q[`ROUTE_MSB:`ROUTE_LSB]),
        .aligned_i   (~loss_lvl),
        .ts0_valid_i (ts0_valid_i),
        .ts0_byte_i  (ts0_byte_i),
        .fas_frame_i (fas_frame_i),
        .dl_bits_q   (dl_bits),
        .dl_mask_q   (dl_mask),
        .dl_valid_q  (dl_valid)
    );

    // Register writes
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            framing_control_q  <= `FRAMING_CONTROL_RESET;
            rx_sig_dl_select_q <= `RX_SIG_DL_SELECT_RESET;
            irq_mask_q         <= 3'h0;
        end else if (wr_i) begin
            case (addr_i)
                `ADDR_FRAMING_CONTROL:  framing_control_q  <= wdata_i;
                `ADDR_RX_SIG_DL_SELECT: rx_sig_dl_select_q <= wdata_i;
                `ADDR_IRQ_MASK:         irq_mask_q         <= wdata_i[2:0];
                default:                framing_control_q  <= framing_control_q;
            endcase
        end
    end

    // Sticky status, set wins over write-one clear
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_stat_q <= 3'h0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~(wr_stat ? wdata_i[2:0] : 3'h0))
                        | {dl_valid, regain_pls, loss_pls};
        end
    end

    // Read data one cycle after strobe
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            case (addr_i)
                `ADDR_FRAMING_CONTROL:  rdata_o <= framing_control_q;
                `ADDR_RX_SIG_DL_SELECT: rdata_o <= rx_sig_dl_select_q;
                `ADDR_IRQ_STATUS:       rdata_o <= {5'h00, irq_stat_q};
                `ADDR_IRQ_MASK:         rdata_o <= {5'h00, irq_mask_q};
                `ADDR_ALIGN_STATUS:     rdata_o <= {5'h00, loss_lvl, loss_lvl, loss_lvl};
                default:                rdata_o <= 8'h00;
            endcase
        end else begin
            rdata_o <= 8'h00;
        end
    end

    // Outputs registered
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            fas_loss_o    <= 1'b0;
            cas_mf_loss_o <= 1'b0;
            crc_mf_loss_o <= 1'b0;
            dl_bits_o     <= 5'h00;
            dl_mask_o     <= 5'h00;
            dl_valid_o    <= 1'b0;
            irq_o         <= 1'b0;
        end else begin
            fas_loss_o    <= loss_lvl;
            cas_mf_loss_o <= loss_lvl;
            crc_mf_loss_o <= loss_lvl;
            dl_bits_o     <= dl_bits;
            dl_mask_o     <= dl_mask;
            dl_valid_o    <= dl_valid;
            irq_o         <= |(irq_stat_q & irq_mask_q);
        end
    end
endmodule

// *** e1_fas_map.vh ***
// Register offsets, fields, reset values and timing counts for the E1 FAS loss block
`ifndef E1_FAS_MAP_VH
`define E1_FAS_MAP_VH
`define ADDR_FRAMING_CONTROL     12'h10b
`define ADDR_RX_SIG_DL_SELECT    12'h10c
`define ADDR_IRQ_STATUS          12'h110
`define ADDR_IRQ_MASK            12'h111
`define ADDR_ALIGN_STATUS        12'h112
`define FRAMING_CONTROL_RESET    8'h03
`define RX_SIG_DL_SELECT_RESET   8'h00
`define CRIT_LSB                 0
`define CRIT_MSB                 2
`define ROUTE_LSB                0
`define ROUTE_MSB                2
`define SA_EN_LSB                3
`define SA_EN_MSB                7
`define ROUTE_DL_A               3'h0
`define ROUTE_DL_B               3'h1
`define ROUTE_DL_C               3'h4
`define IRQ_LOSS_BIT             0
`define IRQ_REGAIN_BIT           1
`define IRQ_DL_BIT               2
`define FAS_WORD                 7'h1b
`define REGAIN_FRAMES            2
`endif

// *** e1_line_src.sv ***
// Far-end line source of timeslot 0 bytes
`timescale 1ns/1ns
module e1_line_src (
    input  wire       clk_i,
    output reg        ts0_valid_o,
    output reg  [7:0] ts0_byte_o,
    output reg        fas_frame_o
);
    initial {ts0_valid_o, ts0_byte_o, fas_frame_o} = 10'h000;
    task send(input logic f, input logic [7:0] b);
        @(posedge clk_i);
        ts0_valid_o <= 1'b1;
        ts0_byte_o  <= b;
        fas_frame_o <= f;
        @(posedge clk_i);
        ts0_valid_o <= 1'b0;
        // Lines not held once the slot is gone
        ts0_byte_o  <= ~b;
        fas_frame_o <= ~f;
    endtask
endmodule

// *** fas_loss_detect.v ***
// Frame alignment checker: counts errored patterns and declares loss
`timescale 1ns/1ns
`include "e1_fas_map.vh"
module fas_loss_detect (
    input  wire       clk_i,
    input  wire       rst_i,
    input  wire [2:0] criteria_i,
    input  wire       ts0_valid_i,
    input  wire [7:0] ts0_byte_i,
    input  wire       fas_frame_i,
    output reg        fas_loss_q,
    output reg        loss_pulse_q,
    output reg        regain_pulse_q
);
    reg [2:0] err_cnt_q;
    reg [1:0] good_cnt_q;
    wire      pattern_ok = (ts0_byte_i[6:0] == `FAS_WORD);
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            err_cnt_q      <= 3'h0;
            good_cnt_q     <= 2'h0;
            fas_loss_q     <= 1'b0;
            loss_pulse_q   <= 1'b0;
            regain_pulse_q <= 1'b0;
        end else begin
            loss_pulse_q   <= 1'b0;
            regain_pulse_q <= 1'b0;
            if (ts0_valid_i && fas_frame_i) begin
                if (!fas_loss_q) begin
                    if (pattern_ok) begin
                        err_cnt_q <= 3'h0;
                    end else if (err_cnt_q + 3'h1 >= criteria_i) begin
                        err_cnt_q    <= 3'h0;
                        fas_loss_q   <= 1'b1;
                        loss_pulse_q <= 1'b1;
                        good_cnt_q   <= 2'h0;
                    end else begin
                        err_cnt_q <= err_cnt_q + 3'h1;
                    end
                end else begin
                    if (!pattern_ok) begin
                        good_cnt_q <= 2'h0;
                    end else if (good_cnt_q == 2'd`REGAIN_FRAMES - 2'h1) begin
                        good_cnt_q     <= 2'h0;
                        fas_loss_q     <= 1'b0;
                        regain_pulse_q <= 1'b1;
                    end else begin
                        good_cnt_q <= good_cnt_q + 2'h1;
                    end
                end
            end
        end
    end
endmodule

// *** sa_datalink_extract.v ***
// Picks enabled national bits of non-FAS timeslot 0 for the data link
`timescale 1ns/1ns
`include "e1_fas_map.vh"
module sa_datalink_extract (
    input  wire       clk_i,
    input  wire       rst_i,
    input  wire [4:0] sa_en_i,
    input  wire [2:0] route_i,
    input  wire       aligned_i,
    input  wire       ts0_valid_i,
    input  wire [7:0] ts0_byte_i,
    input  wire       fas_frame_i,
    output reg  [4:0] dl_bits_q,
    output reg  [4:0] dl_mask_q,
    output reg        dl_valid_q
);
    wire route_ok = (route_i == `ROUTE_DL_A) || (route_i == `ROUTE_DL_B) ||
                    (route_i == `ROUTE_DL_C);
    wire [4:0] eff_en = route_ok ? sa_en_i : 5'h00;
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            dl_bits_q  <= 5'h00;
            dl_mask_q  <= 5'h00;
            dl_valid_q <= 1'b0;
        end else begin
            dl_valid_q <= 1'b0;
            if (ts0_valid_i && !fas_frame_i && aligned_i && (eff_en != 5'h00)) begin
                // per-bit enables, bit 7 down to bit 3
                dl_bits_q  <= ts0_byte_i[7:3] & eff_en;
                dl_mask_q  <= eff_en;
                dl_valid_q <= 1'b1;
            end
        end
    end
endmodule

// *** tb_top.sv ***
// Self-checking bench for alignment loss and data link selection
`timescale 1ns/1ns
`include "e1_fas_map.vh"
module tb_top;
    logic        clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, rd_d = 1'b0;
    logic [11:0] addr_i = 12'h000;
    logic [7:0]  wdata_i = 8'h00, b;
    logic [4:0]  en;
    logic [9:0]  rq[$], dq[$];
    logic [2:0]  crit[3] = '{3'h3, 3'h1, 3'h7};
    int          n_fail = 0, num_checks = 0, seed = 99;
    wire         ts0_valid_i, fas_frame_i, fas_loss_o, cas_mf_loss_o, crc_mf_loss_o;
    wire         dl_valid_o, irq_o;
    wire [7:0]   ts0_byte_i, rdata_o;
    wire [4:0]   dl_bits_o, dl_mask_o;
    e1_line_src i_src (.clk_i, .ts0_valid_o(ts0_valid_i), .ts0_byte_o(ts0_byte_i),
        .fas_frame_o(fas_frame_i));
    e1_fas_loss_and_sa_datalink_select i_e1_fas_loss_and_sa_datalink_select (.clk_i,
        .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .ts0_valid_i, .ts0_byte_i,
        .fas_frame_i, .fas_loss_o, .cas_mf_loss_o, .crc_mf_loss_o, .dl_bits_o,
        .dl_mask_o, .dl_valid_o, .irq_o);
    initial forever #5 clk_i = ~clk_i;
    task cmp(input string s, input logic [9:0] e, input logic [9:0] g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s exp %h got %h", s, e, g);
        end
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i    <= 1'b0;
    endtask
    task rd(input logic [11:0] a, input logic [7:0] e);
        rq.push_back({2'b00, e});
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i   <= 1'b0;
    endtask
    task frames(input int n, input logic [7:0] w);
        repeat (n) begin
            i_src.send(1'b1, w);
            i_src.send(1'b0, 8'h40);
        end
    endtask
    task lv(input string s, input logic e);
        logic g;
        repeat (2) @(posedge clk_i);
        #1;
        case (s)
            "loss":  g = fas_loss_o;
            "cas":   g = cas_mf_loss_o;
            "crc":   g = crc_mf_loss_o;
            default: g = irq_o;
        endcase
        cmp(s, {9'h000, e}, {9'h000, g});
    endtask
    always @(posedge clk_i) begin
        rd_d <= rd_i;
        if (rd_d) cmp("rdata", rq.size() ? rq.pop_front() : 'x, {2'b00, rdata_o});
        if (dl_valid_o === 1'b1)
            cmp("dl", dq.size() ? dq.pop_front() : 'x, {dl_mask_o, dl_bits_o});
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        n_fail++;
        end_sim;
    end
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(`ADDR_FRAMING_CONTROL, `FRAMING_CONTROL_RESET);
        rd(`ADDR_RX_SIG_DL_SELECT, `RX_SIG_DL_SELECT_RESET);
        rd(12'h1ff, 8'h00);
        wr(`ADDR_IRQ_MASK, 8'h01);
        rd(`ADDR_IRQ_MASK, 8'h01);
        foreach (crit[i]) begin
            wr(`ADDR_FRAMING_CONTROL, {5'h00, crit[i]});
            rd(`ADDR_FRAMING_CONTROL, {5'h00, crit[i]});
            frames(crit[i] - 1, 8'h00);
            frames(1, `FAS_WORD);
            frames(crit[i] - 1, 8'h00);
            lv("loss", 1'b0);
            frames(1, 8'h00);
            lv("loss", 1'b1);
            lv("cas", 1'b1);
            lv("crc", 1'b1);
            lv("irq", 1'b1);
            rd(`ADDR_ALIGN_STATUS, 8'h07);
            rd(`ADDR_IRQ_STATUS, 8'h01);
            wr(`ADDR_IRQ_STATUS, 8'h01);
            lv("irq", 1'b0);
            frames(2, `FAS_WORD);
            lv("loss", 1'b0);
            lv("cas", 1'b0);
            lv("crc", 1'b0);
            rd(`ADDR_IRQ_STATUS, 8'h02);
            wr(`ADDR_IRQ_STATUS, 8'h07);
        end
        $display("test loss done");
        for (int r = 0; r < 24; r++) begin
            en = 5'($random(seed));
            b = 8'($random(seed));
            wr(`ADDR_RX_SIG_DL_SELECT, {en, r[2:0]});
            if ((r % 8 == 0 || r % 8 == 1 || r % 8 == 4) && en != 5'h00)
                dq.push_back({en, b[7:3] & en});
            i_src.send(1'b0, b);
            i_src.send(1'b1, `FAS_WORD);
        end
        rd(`ADDR_IRQ_STATUS, 8'h04);
        repeat (4) @(posedge clk_i);
        cmp("dl_left", 10'h000, 10'(dq.size() + rq.size()));
        $display("test dl done");
        end_sim;
    end
endmodule
bind e1_fas_loss_and_sa_datalink_select e1_fas_checker i_chk (.clk_i, .rst_i, .rd_i,
    .rdata_o, .ts0_valid_i, .ts0_byte_i, .fas_frame_i, .fas_loss_o, .cas_mf_loss_o,
    .crc_mf_loss_o, .dl_bits_o, .dl_mask_o, .dl_valid_o);
